// >>> core/adc_ctrl_top.sv
// register side control of the successive-approximation converter
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_ctrl_top
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [11:0] CONV_RESULT,
  input wire logic CONV_ERROR,
  output logic ADC_POWER,
  output logic ADC_CLK_EN,
  output logic THERM_POWER,
  output logic CONV_START,
  output logic [2:0] CONV_CHANNEL,
  output logic IRQ
);
  localparam int CL = CONV_CYCLES;
  localparam logic [2:0] PWRUP = 3'(`PWRUP_CYCLES);

  // refuse lengths the counter cannot hold or the ready check cannot see
  if (CONV_CYCLES < 8 || CONV_CYCLES > (1 << `CNT_W)) begin : g_bad_len
    $error("CONV_CYCLES out of range");
  end

  core_s st;
  core_s n;
  logic setup;
  logic wr;
  logic w_ctrl;
  logic w_div;
  logic w_iraw;
  logic w_ien;
  logic w_ifrc;
  logic div_zero;
  logic trig;
  logic go;
  logic [2:0] rr_sel;
  logic [1:0] clr_raw;
  logic [1:0] set_raw;
  logic clr_sticky;
  logic [31:0] rd;

  // address match used by every decode
  function automatic logic at(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // pacing timer runs only in paced free-running mode
  adc_pace_timer u_pace (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .run(st.many && !div_zero),
    .clear(w_div),
    .div_int(st.div_int),
    .div_frac(st.div_frac),
    .trig(trig)
  );

  // next channel for round-robin sampling
  adc_channel_cycle u_cycle (
    .sel(st.sel),
    .mask(st.mask),
    .next_sel(rr_sel)
  );

  // write strobes, taken at the access edge with pready high
  always_comb begin
    setup = PSEL && !PENABLE;
    wr = PSEL && PENABLE && PWRITE && st.pready;
    w_ctrl = wr && at(PADDR, `OFF_CTRL);
    w_div = wr && at(PADDR, `OFF_DIV); // R12
    w_iraw = wr && at(PADDR, `OFF_IRAW);
    w_ien = wr && at(PADDR, `OFF_IEN);
    w_ifrc = wr && at(PADDR, `OFF_IFRC);
    div_zero = st.div_int == 16'h0000 && st.div_frac == 8'h00;
  end

  // read mux; reserved bits and queue registers read zero
  always_comb begin
    rd = 32'h00000000; // R18
    if (at(PADDR, `OFF_CTRL)) begin
      rd[`F_EN] = st.en;
      rd[`F_TS] = st.ts;
      rd[`F_ONCE] = st.once;
      rd[`F_MANY] = st.many;
      rd[`F_READY] = st.ready; // R5
      rd[`F_ERR] = st.err; // R4
      rd[`F_STICKY] = st.err_sticky; // R3
      rd[`F_SEL_LO +: 3] = st.sel;
      rd[`F_MASK_LO +: 5] = st.mask;
    end else if (at(PADDR, `OFF_SAMPLE)) begin
      rd[11:0] = st.result; // R10
    end else if (at(PADDR, `OFF_DIV)) begin
      rd[`F_DIVI_LO +: 16] = st.div_int;
      rd[7:0] = st.div_frac;
    end else if (at(PADDR, `OFF_IRAW)) begin
      rd[1:0] = st.raw;
    end else if (at(PADDR, `OFF_IEN)) begin
      rd[1:0] = st.ie;
    end else if (at(PADDR, `OFF_IFRC)) begin
      rd[1:0] = st.force_irq;
    end else if (at(PADDR, `OFF_IFIN)) begin
      rd[1:0] = (st.raw & st.ie) | st.force_irq; // R13
    end else begin
      rd = 32'h00000000;
    end
  end

  // next state of the whole block
  always_comb begin
    n = st;
    n.start = 1'b0;
    n.done = 1'b0;
    go = 1'b0;
    clr_sticky = w_ctrl && PWDATA[`F_STICKY];
    clr_raw = w_iraw ? PWDATA[1:0] : 2'h0;
    set_raw = 2'h0;
    // bus answer: one access cycle after every setup cycle
    n.pready = setup;
    n.pslverr = setup && !(at(PADDR, `OFF_CTRL) ||
      at(PADDR, `OFF_SAMPLE) || at(PADDR, `OFF_QCTRL) ||
      at(PADDR, `OFF_QDATA) || at(PADDR, `OFF_DIV) ||
      at(PADDR, `OFF_IRAW) || at(PADDR, `OFF_IEN) ||
      at(PADDR, `OFF_IFRC) || at(PADDR, `OFF_IFIN));
    n.prdata = (setup && !PWRITE) ? rd : 32'h00000000;
    // control writes
    if (w_ctrl) begin
      n.en = PWDATA[`F_EN]; // R9
      n.ts = PWDATA[`F_TS]; // R8
      n.many = PWDATA[`F_MANY];
      n.sel = PWDATA[`F_SEL_LO +: 3]; // R15
      n.mask = PWDATA[`F_MASK_LO +: 5]; // R1
      if (PWDATA[`F_ONCE]) begin
        n.once = 1'b1; // R7
      end
    end
    if (w_div) begin
      n.div_int = PWDATA[`F_DIVI_LO +: 16];
      n.div_frac = PWDATA[7:0];
    end
    if (w_ien) begin
      n.ie = PWDATA[1:0];
    end
    if (w_ifrc) begin
      n.force_irq = PWDATA[1:0];
    end
    // single-shot requests die under free-running or power-down
    if (n.many || !n.en) begin
      n.once = 1'b0; // R7
    end
    // short analogue power-up after enable
    if (!n.en) begin
      n.pwr = 3'h0;
    end else if (st.pwr != PWRUP) begin
      n.pwr = st.pwr + 3'h1;
    end
    // launch: back-to-back, paced, or single; paced ticks lost if busy
    go = n.en && st.ready &&
      (st.once || (st.many && (div_zero || trig))); // R16
    if (!n.en) begin
      n.busy = 1'b0; // R9
    end else if (go) begin
      n.busy = 1'b1; // R14
      n.cnt = `CNT_W'(CL - 1); // R14
      n.start = 1'b1; // R6
      if (st.once) begin
        n.once = 1'b0; // R7
      end
    end else if (st.busy) begin
      if (st.cnt == `CNT_W'(0)) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.result = CONV_RESULT; // R10
        n.err = CONV_ERROR; // R4
        set_raw = {CONV_ERROR, 1'b1};
        if (st.mask != 5'h00) begin
          n.sel = rr_sel; // R2
        end
      end else begin
        n.cnt = st.cnt - `CNT_W'(1);
      end
    end
    // sticky flags: a new event wins over a clear
    n.err_sticky = (st.err_sticky && !clr_sticky) ||
      (n.done && CONV_ERROR); // R3
    n.raw = (st.raw & ~clr_raw) | set_raw;
    n.ready = n.en && n.pwr == PWRUP && !n.busy; // R5
    n.irq = |((n.raw & n.ie) | n.force_irq); // R13
  end

  // single state register
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '0;
      st.sel <= `RST_SEL;
      st.mask <= `RST_MASK;
      st.result <= `RST_RESULT;
      st.div_int <= `RST_DIVI;
      st.div_frac <= `RST_DIVF;
    end else begin
      st <= n;
    end
  end

  // outputs straight from the state register
  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign ADC_POWER = st.en;
  assign ADC_CLK_EN = st.en;
  assign THERM_POWER = st.ts;
  assign CONV_START = st.start;
  assign CONV_CHANNEL = st.sel;
  assign IRQ = st.irq;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);

  property p_busy_low;
    CONV_START |-> !st.ready [*8];
  endproperty
  a_busy_low: assert property (p_busy_low) // R5
    else $error("ready high during conversion");

  property p_conv_len;
    CONV_START |-> ##CL st.done;
  endproperty
  a_conv_len: assert property (p_conv_len) // R14
    else $error("conversion length wrong");

  property p_sticky_hold;
    st.err_sticky && !clr_sticky |=> st.err_sticky;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) // R3
    else $error("sticky error lost");

  property p_sticky_set;
    st.done && st.err |-> st.err_sticky;
  endproperty
  a_sticky_set: assert property (p_sticky_set) // R3
    else $error("sticky error not set");

  property p_result;
    st.done |-> st.result == $past(CONV_RESULT) &&
      st.err == $past(CONV_ERROR);
  endproperty
  a_result: assert property (p_result) // R10
    else $error("result not captured");

  property p_once_many;
    st.many |-> !st.once;
  endproperty
  a_once_many: assert property (p_once_many) // R7
    else $error("single shot under free running");

  property p_back_to_back;
    st.many && div_zero && st.ready && st.en && !w_ctrl |=> CONV_START;
  endproperty
  a_back_to_back: assert property (p_back_to_back) // R6
    else $error("free running did not restart");

  property p_rr_step;
    st.done && $past(st.mask) != 5'h00 && !$past(w_ctrl) |->
      st.mask[st.sel] && st.sel != $past(st.sel) || st.mask == (5'h01 << st.sel);
  endproperty
  a_rr_step: assert property (p_rr_step) // R2
    else $error("channel not advanced");

  property p_power_off;
    !ADC_POWER |-> !st.ready && !st.busy;
  endproperty
  a_power_off: assert property (p_power_off) // R9
    else $error("converter active while off");

  property p_irq;
    IRQ == |((st.raw & st.ie) | st.force_irq);
  endproperty
  a_irq: assert property (p_irq) // R13
    else $error("interrupt output wrong");

  property p_once_clear;
    CONV_START && !st.many && !$past(w_ctrl) |-> !st.once;
  endproperty
  a_once_clear: assert property (p_once_clear) // R7
    else $error("single shot not cleared");

  property p_ready_done;
    st.done && ADC_POWER |-> st.ready;
  endproperty
  a_ready_done: assert property (p_ready_done) // R5
    else $error("not ready after conversion");

  property p_sel_keep;
    st.done && $past(st.mask) == 5'h00 && !$past(w_ctrl) |->
      st.sel == $past(st.sel);
  endproperty
  a_sel_keep: assert property (p_sel_keep) // R1
    else $error("select moved without cycling");

  property p_pace_only;
    st.many && !div_zero && !trig |=> !CONV_START;
  endproperty
  a_pace_only: assert property (p_pace_only) // R11
    else $error("start without pacing tick");

  property p_drop_busy;
    trig && st.busy |=> !CONV_START;
  endproperty
  a_drop_busy: assert property (p_drop_busy) // R16
    else $error("pacing tick queued");

  property p_answer;
    PSEL && !PENABLE |=> PREADY;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no bus answer");

  property p_refuse;
    PREADY && PSLVERR |-> PRDATA == 32'h00000000;
  endproperty
  a_refuse: assert property (p_refuse) // R18
    else $error("refused access returned data");

  property p_sensor;
    w_ctrl |=> THERM_POWER == $past(PWDATA[`F_TS]);
  endproperty
  a_sensor: assert property (p_sensor) // R8
    else $error("sensor power not written");

  property p_enable;
    w_ctrl |=> ADC_POWER == $past(PWDATA[`F_EN]);
  endproperty
  a_enable: assert property (p_enable) // R9
    else $error("converter power not written");
endmodule

// >>> inc/adc_ctrl_defs.svh
// offsets, field positions, reset values and counts of the converter control
// Summary of operation
// R1: five-bit channel mask; zero disables cycling
// R2: cycling starts at input select, then updates it
// R3: sticky error set by errors, write-one clears
// R4: error bit shows last conversion failed
// R5: ready high when idle, low while converting
// R6: free-running repeats conversions, back-to-back when undivided
// R7: single-shot launches one, ignored while free-running
// R8: sensor power bit independent of converter enable
// R9: enable powers converter and gates its clock
// R10: result register holds last twelve-bit value
// R11: nonzero divider paces free-running starts
// R12: any divider write restarts the pacing count
// R13: final status is raw masked plus force
// R14: each conversion lasts 96 converter clocks
// R15: selects 0-3 external inputs, 4 sensor
// R16: pacing trigger during conversion is dropped
// R17: fraction dithers interval between int+1, int+2
// R18: reserved bits read zero, ignore writes
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH
`define OFF_CTRL 8'h00
`define OFF_SAMPLE 8'h04
`define OFF_QCTRL 8'h08
`define OFF_QDATA 8'h0C
`define OFF_DIV 8'h10
`define OFF_IRAW 8'h14
`define OFF_IEN 8'h18
`define OFF_IFRC 8'h1C
`define OFF_IFIN 8'h20
`define F_EN 0
`define F_TS 1
`define F_ONCE 2
`define F_MANY 3
`define F_READY 8
`define F_ERR 9
`define F_STICKY 10
`define F_SEL_LO 12
`define F_MASK_LO 16
`define F_DIVI_LO 8
`define RST_SEL 3'h0
`define RST_MASK 5'h00
`define RST_RESULT 12'h000
`define RST_DIVI 16'h0000
`define RST_DIVF 8'h00
`define CONV_CYCLES 96
`define PWRUP_CYCLES 4
`define CNT_W 7
`define IRQ_W 2
`endif

// >>> inc/adc_ctrl_pkg.sv
// state types of the converter control
package adc_ctrl_pkg;
  typedef struct packed {
    logic en;
    logic ts;
    logic many;
    logic once;
    logic [2:0] sel;
    logic [4:0] mask;
    logic err_sticky;
    logic err;
    logic ready;
    logic busy;
    logic [6:0] cnt;
    logic [2:0] pwr;
    logic [11:0] result;
    logic [15:0] div_int;
    logic [7:0] div_frac;
    logic [1:0] raw;
    logic [1:0] ie;
    logic [1:0] force_irq;
    logic irq;
    logic start;
    logic done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } core_s;

  typedef struct packed {
    logic [16:0] cnt;
    logic [7:0] acc;
    logic trig;
  } pace_s;
endpackage

// >>> core/adc_pace_timer.sv
// pacing timer with first-order fractional dither
`timescale 1ns/1ps
module adc_pace_timer
  import adc_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic run,
  input wire logic clear,
  input wire logic [15:0] div_int,
  input wire logic [7:0] div_frac,
  output logic trig
);
  pace_s st;
  pace_s n;
  logic [8:0] sum;

  // reload with int plus the carry of the fraction accumulator
  always_comb begin
    n = st;
    n.trig = 1'b0;
    sum = {1'b0, st.acc} + {1'b0, div_frac};
    if (clear || !run) begin
      n.cnt = 17'h00000; // R12
      n.acc = 8'h00;
    end else if (st.cnt == 17'h00000) begin
      n.trig = 1'b1; // R11
      n.acc = sum[7:0]; // R17
      n.cnt = {1'b0, div_int} + {16'h0000, sum[8]}; // R17
    end else begin
      n.cnt = st.cnt - 17'h00001;
    end
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  assign trig = st.trig;

  property p_gap;
    @(posedge clock) disable iff (!arst_n)
      st.trig && run && !clear && div_int != 16'h0000 |=> !st.trig;
  endproperty
  a_gap: assert property (p_gap) else $error("pace gap too short"); // R11

  property p_restart;
    @(posedge clock) disable iff (!arst_n)
      clear |=> !st.trig && st.cnt == 17'h00000;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart"); // R12
endmodule

// >>> core/adc_channel_cycle.sv
// picks the next enabled channel after the current one
`timescale 1ns/1ps
module adc_channel_cycle (
  input wire logic [2:0] sel,
  input wire logic [4:0] mask,
  output logic [2:0] next_sel
);
  // nearest set mask bit after sel, wrapping over five channels
  function automatic logic [2:0] next_chan(input logic [2:0] s,
                                           input logic [4:0] m);
    logic [2:0] r;
    int c;
    r = s;
    c = 0;
    for (int i = 5; i >= 1; i--) begin
      c = (int'(s) + i) % 5;
      if (m[c]) begin
        r = 3'(c);
      end
    end
    return r;
  endfunction

  // combinational pick
  always_comb begin
    next_sel = next_chan(sel, mask); // R1
  end
endmodule

// >>> testbench/adc_conv_model.sv
// behavioural converter: answers each start at once and holds the answer through the conversion time
`timescale 1ns/1ps
module adc_conv_model #(
  parameter int CONV_CYCLES = 8
) (
  input wire logic clock,
  input wire logic start,
  input wire logic [2:0] channel,
  input wire logic fail,
  output logic [11:0] result,
  output logic error
);
  int left = 0;
  logic [11:0] val = 12'h000;
  // value holds through a conversion, scrambles every cycle otherwise
  always @(posedge clock) begin
    if (start) begin
      left <= CONV_CYCLES + 2;
      val <= {channel, 9'h0A5};
    end else if (left > 0) begin
      left <= left - 1;
    end else begin
      val <= ~val;
    end
  end
  // error follows the command only while converting
  assign result = val;
  assign error = (left > 0) ? fail : ~val[0];
endmodule

// >>> testbench/adc_control_status_regs_bench.sv
// self-checking bench of the converter register control
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_control_status_regs_bench;
  localparam int CC = 8;
  logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, slverr, cerr, pwr, clk_en, therm, start, irq;
  logic fail = 0;
  logic [11:0] cres;
  logic [2:0] chan;
  int err_count = 0, checked = 0, cyc = 0;
  int st[$];
  logic [2:0] chs[$];
  // clock
  always #50 clock = ~clock;
  // log every conversion start with its cycle and channel
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (start === 1'b1) begin
      st.push_back(cyc);
      chs.push_back(chan);
    end
  end
  adc_ctrl_top #(.CONV_CYCLES(CC)) u_dut (.CLOCK(clock), .ARST_N(arst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CONV_RESULT(cres), .CONV_ERROR(cerr), .ADC_POWER(pwr),
    .ADC_CLK_EN(clk_en), .THERM_POWER(therm), .CONV_START(start),
    .CONV_CHANNEL(chan), .IRQ(irq));
  adc_conv_model #(.CONV_CYCLES(CC)) u_conv (.clock(clock), .start(start),
    .channel(chan), .fail(fail), .result(cres), .error(cerr));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one bus transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    slverr = pslverr;
    chk(n, 1, "wait states");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFF_CTRL, 32'h0);
      n++;
    end while (rd[8] !== 1'b1 && n < 100);
  endtask
  task automatic t_reset();
    logic [7:0] offs[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
      8'h18, 8'h1C, 8'h20};
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      chk(rd, 32'h0, "reset value");
      chk(slverr, 0, "mapped");
    end
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    chk(slverr, 1, "unmapped");
  endtask
  task automatic t_power();
    apb(1'b1, `OFF_CTRL, 32'hFF000002);
    repeat (2) @(negedge clock);
    chk({pwr, clk_en, therm}, 3'b001, "sensor only");
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rd, 32'h2, "reserved");
    apb(1'b1, `OFF_CTRL, 32'h1);
    repeat (2) @(negedge clock);
    chk({pwr, clk_en, therm}, 3'b110, "power");
    wait_ready();
    chk(rd, 32'h101, "ready");
  endtask
  task automatic t_once(input logic [2:0] s, input logic f);
    int n0;
    fail <= f;
    apb(1'b1, `OFF_CTRL, {17'h0, s, 12'h001});
    n0 = st.size();
    apb(1'b1, `OFF_CTRL, {17'h0, s, 12'h005});
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rd[8], 0, "busy");
    chk(rd[2], 0, "self clear");
    wait_ready();
    repeat (3 * CC) @(negedge clock);
    chk(st.size() - n0, 1, "one start");
    chk(chs[$], s, "channel");
    apb(1'b0, `OFF_SAMPLE, 32'h0);
    chk(rd, {20'h0, s, 9'h0A5}, "result");
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rd[9], f, "error");
  endtask
  task automatic t_irq();
    apb(1'b0, `OFF_IRAW, 32'h0);
    chk(rd, 32'h3, "raw");
    chk(irq, 0, "masked");
    apb(1'b1, `OFF_IEN, 32'h1);
    apb(1'b0, `OFF_IFIN, 32'h0);
    chk({rd[30:0], irq}, 32'h3, "enabled");
    apb(1'b1, `OFF_IRAW, 32'h3);
    apb(1'b0, `OFF_IFIN, 32'h0);
    chk({rd[30:0], irq}, 32'h0, "cleared");
    apb(1'b1, `OFF_IFRC, 32'h2);
    apb(1'b0, `OFF_IFIN, 32'h0);
    chk({rd[30:0], irq}, 32'h5, "forced");
    apb(1'b1, `OFF_IFRC, 32'h0);
  endtask
  task automatic t_many();
    int n0;
    logic [2:0] seq[5] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h2};
    n0 = st.size();
    apb(1'b1, `OFF_CTRL, 32'h0006000D);
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rd[2], 0, "once under many");
    repeat (6 * CC) @(negedge clock);
    apb(1'b1, `OFF_CTRL, 32'h1);
    wait_ready();
    foreach (seq[i]) chk(chs[n0 + i], seq[i], "cycle order");
    chk(st[n0 + 2] - st[n0 + 1], CC + 1, "back to back");
  endtask
  task automatic t_pace();
    int n;
    apb(1'b1, `OFF_DIV, 32'h00001400);
    apb(1'b1, `OFF_CTRL, 32'h9);
    repeat (80) @(negedge clock);
    chk(st[$] - st[$ - 1], 21, "paced");
    apb(1'b1, `OFF_DIV, 32'h00001480);
    repeat (130) @(negedge clock);
    apb(1'b1, `OFF_CTRL, 32'h1);
    n = st.size();
    chk(st[n - 1] - st[n - 3], 43, "dither");
    wait_ready();
  endtask
  // closing verdict
  task automatic stop_test();
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(100 * 20000);
    err_count++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_power();
    t_once(3'h2, 1'b0);
    t_once(3'h4, 1'b1);
    t_once(3'h0, 1'b0);
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rd[10], 1, "sticky");
    apb(1'b1, `OFF_CTRL, 32'h401);
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rd[10], 0, "sticky clear");
    t_irq();
    t_many();
    t_pace();
    stop_test();
  end
endmodule
